// ### rtl/sbl_boot_loader.sv
// Behaviour
// (RQ1) In boot mode run the loader that copies a routine into internal RAM.
// (RQ2) Check the password before any RAM transfer; refuse the transfer on mismatch.
// (RQ3) With blank flash the reference password is twelve bytes of FF.
// (RQ4) Loaded routine must sit wholly inside RAM 002000H..009DFFH.
// (RQ5) Straps high, boot strap low while reset low, then release: boot mode.
// (RQ6) In boot mode flash appears at 10000H..8FFFFH.
// (RQ7) In boot mode the loader ROM appears at FFF000H..FFFFFFH.
// (RQ8) Talk only over serial channel one in asynchronous mode.
// (RQ9) Characters are 8 data bits, no parity, one stop bit.
// (RQ10) The controller uses the same character format.
// (RQ11) Init raises clock gear to full speed and enables the PLL.
// (RQ12) Run with interrupts off, polling request flags instead.
// (RQ13) After a good transfer jump to the stored start address.
// (RQ14) Offer a whole-chip erase command without a loaded routine.
// (RQ15) Classify the incoming rate and derive the baud divisor from it.
// (RQ16) Controller rate error plus oscillator error stays within two percent.
// (RQ17) Start at the lowest rate, supported over the whole crystal range.
// (RQ18) Faster rates only come from a loaded routine.
// (RQ19) Session opens with 86H; echo it if accepted, otherwise stop.
// (RQ20) Acknowledge commands: code, x1H error, x6H protected, x8H comm error.
// (RQ21) Twelve password bytes plus checksum, checked before address and data.
// (RQ22) After any error answer, wait for a fresh command byte.
// (RQ23) Sample mode straps only at reset release.
`timescale 1ns/1ps
module sbl_boot_loader
  import sbl_pkg::*;
#(
  parameter int BIT_CYC = CLK_HZ / BAUD_BPS
)(
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    addr_mode_strap_low,
  input  wire logic                    addr_mode_strap_high,
  input  wire logic                    boot_strap_n,
  input  wire logic                    serial_rx_pin,
  output      logic                    serial_tx_pin,
  input  wire logic [8*PW_BYTES-1:0]   pw_ref,
  input  wire logic                    flash_blank,
  input  wire logic                    protect_on,
  input  wire logic                    erase_done,
  output      logic                    boot_mode,
  output      sbl_win_t                flash_win,
  output      logic                    boot_rom_en,
  output      logic                    clk_gear_full,
  output      logic                    pll_en,
  output      logic                    irq_en,
  output      logic [DIV_W-1:0]        baud_div,
  output      logic                    ram_we,
  output      logic [23:0]             ram_addr,
  output      logic [7:0]              ram_wdata,
  output      logic                    flash_erase_req,
  output      logic                    jump_valid,
  output      logic [31:0]             jump_addr,
  output      logic                    halted
);

  localparam int BIT_MIN = (BIT_CYC * (100 - TOL_PCT)) / 100;
  localparam int BIT_MAX = (BIT_CYC * (100 + TOL_PCT) + 99) / 100;

  // Elaboration stops on a bit time that the counters cannot hold
  if (BIT_MIN < 4 || 2 * BIT_MAX >= (1 << DIV_W))
  begin : g_bad_bit_cyc
    $error("BIT_CYC out of range for DIV_W");
  end

  typedef enum logic [3:0] {
    ST_OFF, ST_INIT, ST_SYNC, ST_SYNCB, ST_CMD, ST_ACK, ST_PW, ST_HDR,
    ST_DATA, ST_ERASE, ST_JUMP, ST_HALT
  } sbl_state_t;

  sbl_state_t       st_q, ack_next_q;
  logic             smp_done_q, boot_mode_q;
  logic [DIV_W-1:0] div_q, meas_q;
  logic             meas_run_q;
  sbl_rx_t          rx_out_q;
  logic             rx_act_q;
  logic [DIV_W-1:0] rx_cnt_q;
  logic [3:0]       rx_idx_q;
  logic [7:0]       rx_sh_q;
  logic             tx_go_q, tx_act_q, tx_pin_q, tx_sent_q;
  logic [7:0]       tx_byte_q, cmd_q, sum_q;
  logic [9:0]       tx_sh_q;
  logic [DIV_W-1:0] tx_cnt_q;
  logic [3:0]       tx_idx_q;
  logic [15:0]      cnt_q, len_q;
  logic [31:0]      addr_q;
  logic             pw_ok_q, pw_pass_q, comm_err_q;
  logic             gear_q, pll_q, ram_we_q, erase_q, jump_q, halt_q;
  logic [23:0]      ram_addr_q;
  logic [7:0]       ram_wdata_q;
  sbl_win_t         win_q;

  logic        sync_ok, ck_ok, range_ok;
  logic [31:0] end_addr;
  logic [7:0]  pw_ref_byte;

  // Reference byte for the password compare
  function automatic logic [7:0] pw_byte(input logic [8*PW_BYTES-1:0] ref_v,
                                         input logic blank, input logic [15:0] idx);
    pw_byte = blank ? PW_BLANK : ref_v[8*idx[3:0] +: 8]; // RQ3
  endfunction

  assign sync_ok     = meas_q >= DIV_W'(2 * BIT_MIN) && meas_q <= DIV_W'(2 * BIT_MAX);
  assign ck_ok       = (sum_q + rx_out_q.data) == 8'h00;
  assign end_addr    = addr_q + {16'h0000, len_q} - 32'h0000_0001;
  // End below start means the block wrapped past the top of the space
  assign range_ok    = len_q != 16'h0000 && addr_q >= RAM_LO && end_addr <= RAM_HI
                       && end_addr >= addr_q;
  assign pw_ref_byte = pw_byte(pw_ref, flash_blank, cnt_q);

  ////////////////////////////////////////////////////////////////////////
  // Strap capture, boot mode flag, memory map

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      smp_done_q  <= 1'b0;
      boot_mode_q <= 1'b0;
      win_q       <= '{lo: FLASH_NORM_LO, hi: FLASH_NORM_HI};
    end
    else if (!smp_done_q)
    begin
      // Caught once; later strap changes wait for the next reset
      smp_done_q  <= 1'b1; // RQ23
      boot_mode_q <= addr_mode_strap_low && addr_mode_strap_high && !boot_strap_n; // RQ5
      if (addr_mode_strap_low && addr_mode_strap_high && !boot_strap_n)
        win_q <= '{lo: FLASH_BOOT_LO, hi: FLASH_BOOT_HI}; // RQ6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate detection: low time of start bit plus bit 0 of 86H is two bits

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      meas_run_q <= 1'b0;
      meas_q     <= '0;
    end
    else if (st_q == ST_SYNC)
    begin
      if (!meas_run_q && !serial_rx_pin)
      begin
        meas_run_q <= 1'b1;
        meas_q     <= DIV_W'(1);
      end
      else if (meas_run_q && !serial_rx_pin && meas_q != '1)
        meas_q <= meas_q + DIV_W'(1);
    end
    else
      meas_run_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver, 8N1, flag polled by the sequencer

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_idx_q <= '0;
      rx_sh_q  <= '0;
      rx_out_q <= '0;
    end
    else
    begin
      rx_out_q.valid <= 1'b0;
      if (st_q == ST_SYNC && meas_run_q && serial_rx_pin && sync_ok)
      begin
        // Resume mid-frame: bit 0 already seen low
        rx_act_q <= 1'b1;
        rx_idx_q <= 4'h2;
        rx_cnt_q <= meas_q >> 2;
        rx_sh_q  <= 8'h00;
      end
      else if (!rx_act_q)
      begin
        if (!serial_rx_pin && st_q > ST_SYNCB && st_q < ST_JUMP)
        begin
          rx_act_q <= 1'b1;
          rx_idx_q <= 4'h0;
          rx_cnt_q <= div_q >> 1;
        end
      end
      else if (rx_cnt_q != '0)
        rx_cnt_q <= rx_cnt_q - DIV_W'(1);
      else
      begin
        rx_cnt_q <= div_q - DIV_W'(1);
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0 && serial_rx_pin)
          rx_act_q <= 1'b0;
        else if (rx_idx_q == 4'h9)
        begin
          rx_act_q <= 1'b0;
          rx_out_q <= '{valid: 1'b1, ferr: !serial_rx_pin, data: rx_sh_q}; // RQ9
        end
        else if (rx_idx_q != 4'h0)
          rx_sh_q <= {serial_rx_pin, rx_sh_q[7:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter on serial channel one

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      tx_act_q <= 1'b0;
      tx_pin_q <= 1'b1;
      tx_sh_q  <= '1;
      tx_cnt_q <= '0;
      tx_idx_q <= '0;
    end
    else if (tx_go_q)
    begin
      tx_act_q <= 1'b1;
      tx_sh_q  <= {1'b1, tx_byte_q, 1'b0}; // RQ9
      tx_pin_q <= 1'b0;
      tx_cnt_q <= div_q - DIV_W'(1);
      tx_idx_q <= 4'h0;
    end
    else if (tx_act_q)
    begin
      if (tx_cnt_q != '0)
        tx_cnt_q <= tx_cnt_q - DIV_W'(1);
      else
      begin
        tx_cnt_q <= div_q - DIV_W'(1);
        tx_idx_q <= tx_idx_q + 4'h1;
        tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
        tx_pin_q <= tx_sh_q[1];
        if (tx_idx_q == 4'h9)
          tx_act_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer

  task automatic send_ack(input logic [7:0] b, input sbl_state_t nxt);
    tx_byte_q  <= b;
    ack_next_q <= nxt;
    tx_sent_q  <= 1'b0;
    st_q       <= ST_ACK;
  endtask

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      st_q <= ST_OFF;
      ack_next_q <= ST_CMD;
      div_q <= DIV_W'(BIT_CYC); // RQ17
      tx_go_q <= 1'b0;
      tx_sent_q <= 1'b0;
      tx_byte_q <= '0;
      cmd_q <= '0;
      sum_q <= '0;
      cnt_q <= '0;
      len_q <= '0;
      addr_q <= '0;
      pw_ok_q <= 1'b0;
      pw_pass_q <= 1'b0;
      comm_err_q <= 1'b0;
      gear_q <= 1'b0;
      pll_q <= 1'b0;
      ram_we_q <= 1'b0;
      ram_addr_q <= '0;
      ram_wdata_q <= '0;
      erase_q <= 1'b0;
      jump_q <= 1'b0;
    end
    else
    begin
      tx_go_q  <= 1'b0;
      ram_we_q <= 1'b0;
      unique case (st_q)
        ST_OFF:
          if (smp_done_q && boot_mode_q)
            st_q <= ST_INIT; // RQ1
        ST_INIT:
        begin
          gear_q <= 1'b1; // RQ11
          pll_q  <= 1'b1; // RQ11
          st_q   <= ST_SYNC;
        end
        ST_SYNC:
          if (meas_run_q && serial_rx_pin)
          begin
            if (sync_ok)
            begin
              div_q <= meas_q >> 1; // RQ15
              st_q  <= ST_SYNCB;
            end
            else
              st_q <= ST_HALT; // RQ19
          end
        ST_SYNCB:
          if (rx_out_q.valid)
          begin
            if (!rx_out_q.ferr && rx_out_q.data == BAUD_SYNC)
              send_ack(BAUD_SYNC, ST_CMD); // RQ19
            else
              st_q <= ST_HALT;
          end
        ST_CMD:
          if (rx_out_q.valid)
          begin
            cmd_q <= rx_out_q.data;
            sum_q <= '0;
            cnt_q <= '0;
            pw_ok_q <= 1'b1;
            comm_err_q <= 1'b0;
            if (rx_out_q.ferr)
              send_ack({rx_out_q.data[7:4], NIB_COMM}, ST_CMD); // RQ20
            else if ((rx_out_q.data == CMD_RAM || rx_out_q.data == CMD_ERASE) && protect_on)
              send_ack({rx_out_q.data[7:4], NIB_PROT}, ST_CMD); // RQ20
            else if (rx_out_q.data == CMD_RAM)
              send_ack(CMD_RAM, ST_PW);
            else if (rx_out_q.data == CMD_ERASE)
              send_ack(CMD_ERASE, ST_ERASE); // RQ14
            else
              send_ack({rx_out_q.data[7:4], NIB_ERR}, ST_CMD); // RQ20
          end
        ST_ACK:
          if (!tx_sent_q)
          begin
            tx_go_q   <= 1'b1;
            tx_sent_q <= 1'b1;
          end
          else if (!tx_go_q && !tx_act_q)
            st_q <= ack_next_q; // RQ22
        ST_PW, ST_HDR, ST_DATA:
          if (rx_out_q.valid)
          begin
            cnt_q <= cnt_q + 16'h0001;
            sum_q <= sum_q + rx_out_q.data;
            comm_err_q <= comm_err_q | rx_out_q.ferr;
            if (st_q == ST_PW && cnt_q < 16'(PW_BYTES))
              pw_ok_q <= pw_ok_q && rx_out_q.data == pw_ref_byte; // RQ2
            else if (st_q == ST_HDR && cnt_q < 16'(HDR_BYTES))
            begin
              if (cnt_q < 16'h0004)
                addr_q <= {addr_q[23:0], rx_out_q.data};
              else
                len_q <= {len_q[7:0], rx_out_q.data};
            end
            else if (st_q == ST_DATA && cnt_q < len_q)
            begin
              ram_we_q    <= 1'b1; // RQ1
              ram_addr_q  <= 24'(addr_q + {16'h0000, cnt_q});
              ram_wdata_q <= rx_out_q.data;
            end
            else
            begin
              // Checksum byte closes the block
              cnt_q <= '0;
              sum_q <= '0;
              if (comm_err_q || rx_out_q.ferr)
                send_ack({cmd_q[7:4], NIB_COMM}, ST_CMD); // RQ22
              else if (!ck_ok)
                send_ack({cmd_q[7:4], NIB_ERR}, ST_CMD); // RQ21
              else if (st_q == ST_PW)
              begin
                pw_pass_q <= pw_ok_q;
                send_ack(pw_ok_q ? CMD_RAM : {cmd_q[7:4], NIB_ERR},
                         pw_ok_q ? ST_HDR : ST_CMD); // RQ2
              end
              else if (st_q == ST_HDR)
                send_ack(range_ok ? CMD_RAM : {cmd_q[7:4], NIB_ERR},
                         range_ok ? ST_DATA : ST_CMD); // RQ4
              else
                send_ack(CMD_RAM, ST_JUMP);
            end
          end
        ST_ERASE:
          if (!erase_q)
            erase_q <= 1'b1; // RQ14
          else if (erase_done)
          begin
            erase_q <= 1'b0;
            st_q    <= ST_CMD;
          end
        ST_JUMP:
          jump_q <= 1'b1; // RQ13
        ST_HALT:
          st_q <= ST_HALT;
      endcase
    end
  end

  // Interrupts stay off; the receive flag is polled instead
  assign irq_en          = 1'b0 & boot_mode_q; // RQ12
  assign serial_tx_pin   = tx_pin_q; // RQ8
  assign boot_mode       = boot_mode_q;
  assign flash_win       = win_q;
  assign boot_rom_en     = boot_mode_q; // RQ7
  assign clk_gear_full   = gear_q;
  assign pll_en          = pll_q;
  assign baud_div        = div_q;
  assign ram_we          = ram_we_q;
  assign ram_addr        = ram_addr_q;
  assign ram_wdata       = ram_wdata_q;
  assign flash_erase_req = erase_q;
  assign jump_valid      = jump_q;
  assign jump_addr       = addr_q;
  assign halted          = halt_q;

  // Registered so the stop flag leaves the block straight from a flop
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      halt_q <= 1'b0;
    else
      halt_q <= st_q == ST_HALT; // RQ19
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_strap_hold: assert property (smp_done_q |=> $stable(boot_mode_q)) // RQ23
    else $error("mode changed after reset release");
  a_pw_refuse: assert property (ram_we_q |-> pw_pass_q && pw_ok_q) // RQ2
    else $error("RAM write without password");
  a_ram_window: assert property (ram_we_q |-> ram_addr_q >= RAM_LO[23:0]
                                 && ram_addr_q <= RAM_HI[23:0]) // RQ4
    else $error("RAM write outside window");
  a_sync_echo: assert property (st_q == ST_SYNCB && rx_out_q.valid && !rx_out_q.ferr
                                && rx_out_q.data == BAUD_SYNC
                                |-> ##[1:3] tx_go_q && tx_byte_q == BAUD_SYNC) // RQ19
    else $error("sync byte not echoed");
  a_sync_halt: assert property (st_q == ST_SYNC && meas_run_q && serial_rx_pin && !sync_ok
                                |=> st_q == ST_HALT [*2]) // RQ19
    else $error("bad rate did not halt");
  a_boot_map: assert property (smp_done_q && boot_mode_q |-> win_q.lo == FLASH_BOOT_LO
                               && win_q.hi == FLASH_BOOT_HI && boot_rom_en) // RQ6
    else $error("boot map wrong");
  a_gear_pll: assert property ($rose(st_q == ST_SYNC) |-> gear_q && pll_q) // RQ11
    else $error("clock not raised before sync");
  a_no_irq: assert property (boot_mode_q |-> !irq_en) // RQ12
    else $error("interrupts enabled");
  a_jump_addr: assert property ($rose(jump_q) |-> $past(st_q) == ST_JUMP
                                && jump_addr >= RAM_LO && jump_addr <= RAM_HI) // RQ13
    else $error("jump address wrong");
  a_tx_start: assert property (tx_go_q |=> !tx_pin_q ##1 tx_act_q) // RQ9
    else $error("no start bit");

endmodule

// ### rtl/sbl_pkg.sv
package sbl_pkg;

  // Clock and serial timing
  localparam int CLK_HZ   = 100_000_000;
  localparam int BAUD_BPS = 9600;
  localparam int TOL_PCT  = 2;
  localparam int DIV_W    = 16;

  // Protocol bytes
  localparam logic [7:0] BAUD_SYNC = 8'h86;
  localparam logic [7:0] CMD_RAM   = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h40;
  localparam logic [3:0] NIB_ERR   = 4'h1;
  localparam logic [3:0] NIB_PROT  = 4'h6;
  localparam logic [3:0] NIB_COMM  = 4'h8;
  localparam logic [7:0] PW_BLANK  = 8'hFF;
  localparam int         PW_BYTES  = 12;
  localparam int         HDR_BYTES = 6;

  // Address windows
  localparam logic [31:0] RAM_LO        = 32'h0000_2000;
  localparam logic [31:0] RAM_HI        = 32'h0000_9DFF;
  localparam logic [23:0] FLASH_BOOT_LO = 24'h01_0000;
  localparam logic [23:0] FLASH_BOOT_HI = 24'h08_FFFF;
  localparam logic [23:0] FLASH_NORM_LO = 24'hF8_0000;
  localparam logic [23:0] FLASH_NORM_HI = 24'hFF_FFFF;
  localparam logic [23:0] ROM_LO        = 24'hFF_F000;
  localparam logic [23:0] ROM_HI        = 24'hFF_FFFF;

  typedef struct packed {
    logic       valid;
    logic       ferr;
    logic [7:0] data;
  } sbl_rx_t;

  typedef struct packed {
    logic [23:0] lo;
    logic [23:0] hi;
  } sbl_win_t;

endpackage

// ### tb/sbl_ctl_model.sv
`timescale 1ns/1ps
module sbl_ctl_model
#(
  parameter int BIT_CYC = 40
)(
  input  wire logic ref_clk,
  output      logic tx_line,
  input  wire logic rx_line
);
  logic [7:0] rxq[$];
  logic [7:0] rx_b;
  int         k;

  initial tx_line = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed 8N1 at the lowest rate; never switches speed itself
  task automatic send_byte(input logic [7:0] b, input logic stp);
    int i;
    @(posedge ref_clk);
    tx_line <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge ref_clk);
      tx_line <= b[i];
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    tx_line <= stp;
    repeat (BIT_CYC) @(posedge ref_clk);
    // Low stop only for framing tests; the line idles high after it
    tx_line <= 1'b1;
  endtask

  task automatic get_byte(output logic [7:0] b, output bit got, input int lim);
    int n;
    got = 1'b0;
    b   = 8'hXX;
    for (n = 0; n < lim && !got; n++)
    begin
      @(posedge ref_clk);
      if (rxq.size() > 0)
      begin
        b   = rxq.pop_front();
        got = 1'b1;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Mid-bit sampling; exact rate keeps error well inside two percent
  always
  begin
    @(negedge rx_line);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    if (rx_line == 1'b0)
    begin
      for (k = 0; k < 8; k++)
      begin
        repeat (BIT_CYC) @(posedge ref_clk);
        rx_b[k] = rx_line;
      end
      repeat (BIT_CYC) @(posedge ref_clk);
      // Framing error bytes dropped: a missing ack then times out
      if (rx_line === 1'b1)
        rxq.push_back(rx_b);
    end
  end
endmodule

// ### tb/serial_boot_loader_bench.sv
`timescale 1ns/1ps
module serial_boot_loader_bench;
  import sbl_pkg::*;
  localparam int BC    = 40;
  localparam int LIMIT = 100000;

  logic             ref_clk;
  logic             resetn;
  logic             am_lo;
  logic             am_hi;
  logic             boot_n;
  logic             rx;
  logic             tx;
  logic [95:0]      pw_ref;
  logic             flash_blank;
  logic             protect_on;
  logic             erase_done;
  logic             boot_mode;
  sbl_win_t         flash_win;
  logic             boot_rom_en;
  logic             gear;
  logic             pll;
  logic             irq_en;
  logic [DIV_W-1:0] baud_div;
  logic             ram_we;
  logic [23:0]      ram_addr;
  logic [7:0]       ram_wdata;
  logic             erase_req;
  logic             jump_valid;
  logic [31:0]      jump_addr;
  logic             halted;
  logic [31:0]      wq[$];
  int               n_mismatch;
  int               checked;
  int               cyc;

  sbl_boot_loader #(.BIT_CYC(BC)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .addr_mode_strap_low(am_lo),
    .addr_mode_strap_high(am_hi), .boot_strap_n(boot_n), .serial_rx_pin(rx),
    .serial_tx_pin(tx), .pw_ref(pw_ref), .flash_blank(flash_blank),
    .protect_on(protect_on), .erase_done(erase_done), .boot_mode(boot_mode),
    .flash_win(flash_win), .boot_rom_en(boot_rom_en), .clk_gear_full(gear),
    .pll_en(pll), .irq_en(irq_en), .baud_div(baud_div), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .flash_erase_req(erase_req),
    .jump_valid(jump_valid), .jump_addr(jump_addr), .halted(halted));

  sbl_ctl_model #(.BIT_CYC(BC)) u_ctl (.ref_clk(ref_clk), .tx_line(rx), .rx_line(tx));

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    if (resetn && ram_we === 1'b1)
      wq.push_back({ram_addr, ram_wdata});
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic expect_ack(input logic [7:0] exp, input string what);
    logic [7:0] b;
    bit         got;
    u_ctl.get_byte(b, got, 30 * BC);
    check(what, {40'h0, b}, {40'h0, exp});
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] exp);
    u_ctl.send_byte(c, 1'b1);
    expect_ack(exp, "command ack");
  endtask

  // Checksum byte makes the block sum zero; bad adds one to break it
  task automatic send_blk(input logic [7:0] q[$], input bit bad);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i])
    begin
      u_ctl.send_byte(q[i], 1'b1);
      s = s + q[i];
    end
    u_ctl.send_byte(8'h00 - s + {7'h0, bad}, 1'b1);
  endtask

  task automatic do_reset(input logic bn);
    resetn <= 1'b0;
    am_lo  <= 1'b1;
    am_hi  <= 1'b1;
    boot_n <= bn;
    repeat (8) @(posedge ref_clk);
    check("gear in reset", {47'h0, gear}, 48'h0);
    check("window in reset", flash_win, {FLASH_NORM_LO, FLASH_NORM_HI});
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot_entry();
    do_reset(1'b0);
    check("boot mode", {47'h0, boot_mode}, 48'h1);
    check("flash window", flash_win, {FLASH_BOOT_LO, FLASH_BOOT_HI});
    check("rom enable", {47'h0, boot_rom_en}, 48'h1);
    check("gear and pll", {46'h0, gear, pll}, 48'h3);
    check("irq enable", {47'h0, irq_en}, 48'h0);
    check("divisor", {32'h0, baud_div}, BC);
    boot_n <= 1'b1;
    am_lo  <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check("straps latched", {47'h0, boot_mode}, 48'h1);
    u_ctl.send_byte(BAUD_SYNC, 1'b1);
    expect_ack(BAUD_SYNC, "sync echo");
  endtask

  task automatic t_errors();
    // Command with a low stop bit must draw the comm error answer
    u_ctl.send_byte(CMD_RAM, 1'b0);
    expect_ack({CMD_RAM[7:4], NIB_COMM}, "framing ack");
    cmd(8'h55, 8'h51);
    protect_on <= 1'b1;
    cmd(CMD_RAM, {CMD_RAM[7:4], NIB_PROT});
    cmd(CMD_ERASE, {CMD_ERASE[7:4], NIB_PROT});
    protect_on <= 1'b0;
  endtask

  task automatic t_erase();
    int n;
    cmd(CMD_ERASE, CMD_ERASE);
    // Ack stop bit still runs about 20 cycles before the erase state
    repeat (40) @(posedge ref_clk);
    check("erase request", {47'h0, erase_req}, 48'h1);
    erase_done <= 1'b1;
    @(posedge ref_clk);
    erase_done <= 1'b0;
    for (n = 0; n < 5 && erase_req !== 1'b0; n++)
      @(posedge ref_clk);
    check("erase released", {47'h0, erase_req}, 48'h0);
  endtask

  task automatic pw_phase(input bit use_ref, input bit bad, input logic [7:0] exp);
    logic [7:0] q[$];
    int         i;
    cmd(CMD_RAM, CMD_RAM);
    for (i = 0; i < PW_BYTES; i++)
      q.push_back(use_ref ? pw_ref[8*i +: 8] : (flash_blank ? PW_BLANK : 8'h5A));
    send_blk(q, bad);
    expect_ack(exp, "password ack");
  endtask

  task automatic hdr(input logic [31:0] a, input logic [15:0] n, input logic [7:0] exp);
    send_blk('{a[31:24], a[23:16], a[15:8], a[7:0], n[15:8], n[7:0]}, 1'b0);
    expect_ack(exp, "header ack");
  endtask

  task automatic t_password();
    pw_phase(1'b0, 1'b0, 8'h11);
    pw_phase(1'b1, 1'b1, 8'h11);
    pw_phase(1'b1, 1'b0, 8'h10);
    hdr(32'h0000_9DFE, 16'h0003, 8'h11);
    check("no ram writes", wq.size(), 48'h0);
    check("no jump", {47'h0, jump_valid}, 48'h0);
  endtask

  task automatic t_load();
    flash_blank <= 1'b1;
    pw_phase(1'b0, 1'b0, 8'h10);
    hdr(32'h0000_9DFD, 16'h0003, 8'h10);
    send_blk('{8'hA1, 8'hB2, 8'hC3}, 1'b0);
    expect_ack(CMD_RAM, "data ack");
    check("write count", wq.size(), 48'h3);
    check("write 0", wq[0], 48'h9DFDA1);
    check("write 2", wq[2], 48'h9DFFC3);
    // Jump follows only once the ack stop bit has left the pin
    repeat (30) @(posedge ref_clk);
    check("jump", {15'h0, jump_valid, jump_addr}, 48'h1_0000_9DFD);
  endtask

  task automatic t_halt();
    logic [7:0] b;
    bit         got;
    do_reset(1'b1);
    check("normal mode", {46'h0, boot_mode, boot_rom_en}, 48'h0);
    check("normal window", flash_win, {FLASH_NORM_LO, FLASH_NORM_HI});
    do_reset(1'b0);
    u_ctl.send_byte(8'hC6, 1'b1);
    u_ctl.get_byte(b, got, 30 * BC);
    check("no echo", {47'h0, got}, 48'h0);
    check("halted", {47'h0, halted}, 48'h1);
    // Three low bits up front: rate measurement itself must refuse
    do_reset(1'b0);
    u_ctl.send_byte(8'h84, 1'b1);
    u_ctl.get_byte(b, got, 30 * BC);
    check("no echo bad rate", {47'h0, got}, 48'h0);
    check("halted bad rate", {47'h0, halted}, 48'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_mismatch  = 0;
    checked     = 0;
    cyc         = 0;
    resetn      = 1'b0;
    am_lo       = 1'b1;
    am_hi       = 1'b1;
    boot_n      = 1'b0;
    pw_ref      = 96'h0C0B0A09_08070605_04030201;
    flash_blank = 1'b0;
    protect_on  = 1'b0;
    erase_done  = 1'b0;
    t_boot_entry();
    t_errors();
    t_erase();
    t_password();
    t_load();
    t_halt();
    print_verdict();
  end
endmodule
